// *** hw/instr_cycle_decode.sv ***
// Purpose: Decode 14-bit instruction words, sequence their cycles and phases
// Assumes: i_clk is the oscillator; all inputs come from same-clock core logic
// Notes: A new word is taken only in phase Q4 of an idle or final cycle

// How it works
// (RL1) One 14-bit word holds opcode and operands
// (RL2) Classify into byte, bit, literal/control
// (RL3) Default instruction length is one cycle
// (RL4) Both subroutine invoke forms take two cycles
// (RL5) All return forms take two cycles
// (RL6) Jumps and skips take two cycles
// (RL7) Indirect access to program memory adds one
// (RL8) Four oscillator clocks per instruction cycle
// (RL9) File operand is always read first
// (RL10) Result written where instruction or d says
// (RL11) d zero to accumulator, one to file
// (RL12) File address spans 0x00 to 0x7F
// (RL13) Bit index picks one of eight bits
// (RL14) Pointer select chooses pair zero or one
// (RL15) Don't-care bits accepted as either value
// (RL16) Step mode selects pre/post increment/decrement
// (RL17) Byte ops: address bits 6:0, d bit 7
// (RL18) Jump and invoke carry 11-bit target
// (RL19) Step ops: mode 1:0, select bit 2
// (RL20) Single 8-bit accumulator operand and destination
module instr_cycle_decode
    import instr_cycle_pkg::*;
#(
    parameter int unsigned NUM_PTR = 2
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [instr_cycle_pkg::INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [NUM_PTR-1:0] i_ptr_in_progmem,
    input wire logic [instr_cycle_pkg::DATA_W-1:0] i_result,
    output logic o_instr_ready,
    output logic o_busy,
    output logic [1:0] o_phase,
    output logic [1:0] o_cycle_index,
    output logic [1:0] o_total_cycles_m1,
    output instr_cycle_pkg::group_t o_group,
    output logic [instr_cycle_pkg::FILE_W-1:0] o_file_addr,
    output logic o_dest_file,
    output logic [2:0] o_bit_index,
    output logic [7:0] o_lit8,
    output logic [10:0] o_lit11,
    output logic [8:0] o_lit9,
    output logic [6:0] o_lit7,
    output logic [5:0] o_lit6,
    output logic [4:0] o_lit5,
    output logic o_ptr_sel,
    output instr_cycle_pkg::step_mode_sel_t o_step_mode,
    output logic o_flow_change,
    output logic o_file_read,
    output logic o_file_write,
    output logic o_acc_write,
    output logic [instr_cycle_pkg::DATA_W-1:0] o_acc
);
    import instr_cycle_pkg::*;

    typedef enum logic {
        ST_WAIT,
        ST_RUN
    } state_t;

    state_t state;
    logic [1:0] phase;
    logic [1:0] cycle_index;
    logic last_cycle;
    logic take;

    logic names_file;
    logic writes_file;
    logic writes_acc;

    logic [5:0] op6;
    group_t next_group;
    logic [1:0] next_cycles_m1;
    logic next_names_file;
    logic next_writes_file;
    logic next_writes_acc;
    logic next_flow;
    logic next_ptr_sel;
    logic next_indirect;
    logic byte_file_op;
    logic bit_op;
    logic is_invoke;
    logic is_exit;
    logic is_jump;
    logic is_skip;
    logic lengthen;

    // (RL1) Every field comes out of the one word
    assign op6 = i_instr[INSTR_W-1:INSTR_W-6];

    // (RL8) Free-running four-phase counter
    // Phase runs even when idle so cycle boundaries never drift
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            phase <= PHASE_Q1;
        else
            phase <= phase + PHASE_STEP;
    end

    assign last_cycle = (cycle_index == o_total_cycles_m1);
    // Combinational so a word pending in the last cycle starts with no gap
    assign o_instr_ready = (phase == PHASE_Q4) && ((state == ST_WAIT) || last_cycle);
    assign take = o_instr_ready && i_instr_valid;

    // (RL2) Group and operand usage classification
    always_comb
    begin
        byte_file_op = 1'b0;
        bit_op = 1'b0;
        next_group = GROUP_LITCTRL;
        next_writes_acc = 1'b0;
        next_writes_file = 1'b0;
        if (i_instr[13:12] == GRP_BIT)
        begin
            bit_op = 1'b1;
            next_group = GROUP_BIT;
            // Skips only test the bit; set and clear write back
            next_writes_file = !i_instr[11];
        end
        else if (op6 == OP_CTRL)
        begin
            // (RL10) Store to file is fixed by bit 7 here
            byte_file_op = i_instr[7];
            next_writes_file = i_instr[7];
            next_group = i_instr[7] ? GROUP_BYTE : GROUP_LITCTRL;
        end
        else if (op6 == OP_CLEAR)
        begin
            // (RL15) Low bits of clear-accumulator are ignored
            byte_file_op = i_instr[7];
            next_group = GROUP_BYTE;
            next_writes_file = i_instr[7];
            next_writes_acc = !i_instr[7];
        end
        else if ((i_instr[13:12] == 2'h0) || (op6 == OP_SHIFT_A) || (op6 == OP_SHIFT_B)
            || (op6 == OP_SHIFT_C) || (op6 == OP_SUB_BORROW) || (op6 == OP_ADD_CARRY))
        begin
            byte_file_op = 1'b1;
            next_group = GROUP_BYTE;
            // (RL11) d selects accumulator or file
            next_writes_file = i_instr[7];
            next_writes_acc = !i_instr[7];
        end
        else
        begin
            // (RL20) Literal ops and literal exit load the accumulator
            next_writes_acc = (op6 == OP_LOAD_LIT) || (op6 == OP_OR_LIT)
                || (op6 == OP_AND_LIT) || (op6 == OP_XOR_LIT) || (op6 == OP_SUB_LIT)
                || (op6 == OP_ADD_LIT) || (op6 == OP_EXIT_LIT);
        end
    end

    // (RL9) Any file operand gets a read, even write-only ones
    assign next_names_file = byte_file_op || bit_op;

    // (RL14) Pointer select from bit 2 or bit 6, else from address
    always_comb
    begin
        next_ptr_sel = i_instr[0];
        next_indirect = 1'b0;
        if (next_names_file)
        begin
            next_ptr_sel = i_instr[0];
            next_indirect = (i_instr[6:1] == IND_PORT_HI);
        end
        else if ((op6 == OP_CTRL) && (i_instr[13:4] == OP_PTR_STEP))
        begin
            next_ptr_sel = i_instr[2];
            next_indirect = 1'b1;
        end
        else if ((i_instr[13:7] == OP_PTR_OFS_RD) || (i_instr[13:7] == OP_PTR_OFS_WR))
        begin
            next_ptr_sel = i_instr[6];
            next_indirect = 1'b1;
        end
        else if (i_instr[13:7] == OP_PTR_ADD)
        begin
            next_ptr_sel = i_instr[6];
        end
    end

    // (RL4) Direct and computed invoke
    assign is_invoke = (i_instr[13:11] == OP_INVOKE) || (i_instr == OP_INVOKE_COMP);

    // (RL5) Subroutine, literal and interrupt exits
    assign is_exit = (i_instr == OP_SUB_EXIT) || (i_instr == OP_INT_EXIT)
        || (op6 == OP_EXIT_LIT);

    // (RL6) Absolute, relative and accumulator jumps
    assign is_jump = (i_instr[13:11] == OP_ABS_JUMP) || (i_instr[13:9] == OP_REL_JUMP)
        || (i_instr == OP_JUMP_ACC);

    // (RL6) Bit tests and count-and-skip
    // No skip-taken input exists, so a skip always costs the second cycle
    assign is_skip = (bit_op && ((i_instr[11:10] == BIT_SKIP_ZERO)
        || (i_instr[11:10] == BIT_SKIP_ONE)))
        || (op6 == OP_DEC_SKIP) || (op6 == OP_INC_SKIP);

    // (RL7) Indirect access into program memory costs one more
    assign lengthen = next_indirect && i_ptr_in_progmem[next_ptr_sel];

    assign next_flow = is_invoke || is_exit || is_jump || is_skip;

    // Cycle count of the incoming word
    always_comb
    begin
        // (RL3) One cycle unless a flow change or lengthened
        next_cycles_m1 = CYC_ONE_M1;
        if (next_flow)
            next_cycles_m1 = next_cycles_m1 + CYC_STEP;
        if (lengthen)
            next_cycles_m1 = next_cycles_m1 + CYC_STEP;
    end

    // Sequencer over the cycles of one instruction
    // Words offered while not ready simply stay pending; nothing flags them
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            state <= ST_WAIT;
            cycle_index <= 2'h0;
        end
        else if (take)
        begin
            state <= ST_RUN;
            cycle_index <= 2'h0;
        end
        else if ((state == ST_RUN) && (phase == PHASE_Q4))
        begin
            case (state)
                ST_RUN:
                begin
                    if (last_cycle)
                        state <= ST_WAIT;
                    else
                        cycle_index <= cycle_index + CYC_STEP;
                end
                default:
                    state <= ST_WAIT;
            endcase
        end
    end

    // Decoded operand fields, held for the whole instruction
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_group <= GROUP_LITCTRL;
            o_file_addr <= '0;
            o_dest_file <= 1'b1;
            o_bit_index <= 3'h0;
            o_ptr_sel <= 1'b0;
            o_step_mode <= STEP_PRE_INC;
        end
        else if (take)
        begin
            o_group <= next_group;
            // (RL12) (RL17) Address in bits 6:0 covers the window
            o_file_addr <= i_instr[FILE_W-1:0];
            // (RL11) (RL17) d in bit 7
            o_dest_file <= i_instr[7];
            // (RL13) Bit index in bits 9:7
            o_bit_index <= i_instr[9:7];
            o_ptr_sel <= next_ptr_sel;
            // (RL16) (RL19) Step mode in bits 1:0
            o_step_mode <= step_mode_sel_t'(i_instr[1:0]);
        end
    end

    // Literal views of the word; the core picks the one its opcode uses
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_lit8 <= 8'h00;
            o_lit11 <= 11'h000;
            o_lit9 <= 9'h000;
            o_lit7 <= 7'h00;
            o_lit6 <= 6'h00;
            o_lit5 <= 5'h00;
        end
        else if (take)
        begin
            o_lit8 <= i_instr[7:0];
            // (RL18) Target in bits 10:0
            o_lit11 <= i_instr[10:0];
            o_lit9 <= i_instr[8:0];
            o_lit7 <= i_instr[6:0];
            o_lit6 <= i_instr[5:0];
            o_lit5 <= i_instr[4:0];
        end
    end

    // Per-instruction length and operand usage, held until the next take
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_total_cycles_m1 <= CYC_ONE_M1;
            o_flow_change <= 1'b0;
            names_file <= 1'b0;
            writes_file <= 1'b0;
            writes_acc <= 1'b0;
        end
        else if (take)
        begin
            o_total_cycles_m1 <= next_cycles_m1;
            o_flow_change <= next_flow;
            names_file <= next_names_file;
            writes_file <= next_writes_file;
            writes_acc <= next_writes_acc;
        end
    end

    // (RL9) Read strobe in Q2 of the first cycle
    assign o_file_read = (state == ST_RUN) && names_file && (cycle_index == 2'h0)
        && (phase == PHASE_Q2);
    // (RL10) Write back in Q4 of the final cycle
    assign o_file_write = (state == ST_RUN) && writes_file && last_cycle
        && (phase == PHASE_Q4);
    assign o_acc_write = (state == ST_RUN) && writes_acc && last_cycle
        && (phase == PHASE_Q4);

    // (RL20) Single accumulator loaded from the result bus
    // Loaded on the strobe edge, so i_result must be settled by the end of Q4
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            o_acc <= '0;
        else if (o_acc_write)
            o_acc <= i_result;
    end

    assign o_busy = (state == ST_RUN);
    assign o_phase = phase;
    assign o_cycle_index = cycle_index;
endmodule : instr_cycle_decode

// *** hw/instr_cycle_pkg.sv ***
// Purpose: Shared constants and types for the instruction cycle decoder
// Assumes: 14-bit instruction words, four oscillator clocks per instruction cycle
// Notes: Opcode patterns are compared under masks so don't-care bits never matter
package instr_cycle_pkg;
    localparam int unsigned INSTR_W = 14;
    localparam int unsigned FILE_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned OSC_PER_CYCLE = 4;

    // Oscillator phases inside one instruction cycle
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam logic [1:0] PHASE_STEP = 2'h1;

    // Cycle counts (stored as count minus one)
    localparam logic [1:0] CYC_ONE_M1 = 2'h0;
    localparam logic [1:0] CYC_STEP = 2'h1;

    // Six-bit major opcodes (bits 13:8)
    localparam logic [5:0] OP_CTRL = 6'h00;
    localparam logic [5:0] OP_CLEAR = 6'h01;
    localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
    localparam logic [5:0] OP_INC_SKIP = 6'h0f;
    localparam logic [5:0] OP_EXIT_LIT = 6'h34;
    localparam logic [5:0] OP_SHIFT_A = 6'h35;
    localparam logic [5:0] OP_SHIFT_B = 6'h36;
    localparam logic [5:0] OP_SHIFT_C = 6'h37;
    localparam logic [5:0] OP_SUB_BORROW = 6'h3b;
    localparam logic [5:0] OP_ADD_CARRY = 6'h3d;
    localparam logic [5:0] OP_LOAD_LIT = 6'h30;
    localparam logic [5:0] OP_OR_LIT = 6'h38;
    localparam logic [5:0] OP_AND_LIT = 6'h39;
    localparam logic [5:0] OP_XOR_LIT = 6'h3a;
    localparam logic [5:0] OP_SUB_LIT = 6'h3c;
    localparam logic [5:0] OP_ADD_LIT = 6'h3e;

    // Other opcode prefixes
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] BIT_SKIP_ZERO = 2'h2;
    localparam logic [1:0] BIT_SKIP_ONE = 2'h3;
    localparam logic [2:0] OP_INVOKE = 3'h4;
    localparam logic [2:0] OP_ABS_JUMP = 3'h5;
    localparam logic [4:0] OP_REL_JUMP = 5'h19;
    localparam logic [6:0] OP_PTR_ADD = 7'h62;
    localparam logic [6:0] OP_PAGE_LIT = 7'h63;
    localparam logic [6:0] OP_PTR_OFS_RD = 7'h7e;
    localparam logic [6:0] OP_PTR_OFS_WR = 7'h7f;
    localparam logic [9:0] OP_PTR_STEP = 10'h001;
    localparam logic [8:0] OP_BANK_LIT = 9'h001;
    localparam logic [13:0] OP_SUB_EXIT = 14'h0008;
    localparam logic [13:0] OP_INT_EXIT = 14'h0009;
    localparam logic [13:0] OP_INVOKE_COMP = 14'h000a;
    localparam logic [13:0] OP_JUMP_ACC = 14'h000b;

    // Indirect access ports sit at the bottom of every window
    localparam logic [5:0] IND_PORT_HI = 6'h00;

    typedef enum logic [1:0] {
        GROUP_BYTE,
        GROUP_BIT,
        GROUP_LITCTRL
    } group_t;

    typedef enum logic [1:0] {
        STEP_PRE_INC,
        STEP_PRE_DEC,
        STEP_POST_INC,
        STEP_POST_DEC
    } step_mode_sel_t;
endpackage : instr_cycle_pkg

// *** sim/instr_cycle_decode_assertions.sv ***
// Purpose: Port-level timing and field checks for the instruction decoder
// Assumes: One clock domain, synchronous active-low reset
// Notes: A take is ready and valid together on a rising edge
module instr_cycle_decode_assertions
    import instr_cycle_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [instr_cycle_pkg::INSTR_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [instr_cycle_pkg::DATA_W-1:0] i_result,
    input wire logic o_instr_ready,
    input wire logic o_busy,
    input wire logic [1:0] o_phase,
    input wire logic [1:0] o_cycle_index,
    input wire logic [1:0] o_total_cycles_m1,
    input wire instr_cycle_pkg::group_t o_group,
    input wire logic [instr_cycle_pkg::FILE_W-1:0] o_file_addr,
    input wire logic o_dest_file,
    input wire logic [2:0] o_bit_index,
    input wire logic [10:0] o_lit11,
    input wire instr_cycle_pkg::step_mode_sel_t o_step_mode,
    input wire logic o_flow_change,
    input wire logic o_file_read,
    input wire logic o_file_write,
    input wire logic o_acc_write,
    input wire logic [instr_cycle_pkg::DATA_W-1:0] o_acc
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic take;
    assign take = o_instr_ready && i_instr_valid;
    AST_PHASE_STEP: assert property ($past(i_rst_b) |-> o_phase == 2'($past(o_phase) + 2'h1))
        else $error("phase did not advance by one");
    AST_READY_Q4: assert property (o_instr_ready |-> o_phase == PHASE_Q4)
        else $error("ready outside the last phase");
    AST_TAKE_BUSY: assert property (take |=> o_busy && o_cycle_index == 2'h0)
        else $error("take did not start cycle zero");
    AST_BYTE_FIELDS: assert property (take |=> o_file_addr == $past(i_instr[6:0]) &&
        o_dest_file == $past(i_instr[7])) else $error("file address or destination wrong");
    AST_BIT_INDEX: assert property (take |=> o_bit_index == $past(i_instr[9:7]))
        else $error("bit index wrong");
    AST_JUMP_TARGET: assert property (take |=> o_lit11 == $past(i_instr[10:0]))
        else $error("long target wrong");
    AST_STEP_MODE: assert property (take |=> o_step_mode == step_mode_sel_t'($past(i_instr[1:0])))
        else $error("step mode wrong");
    AST_INVOKE_LEN: assert property (take && i_instr[13:11] == OP_INVOKE |=>
        o_total_cycles_m1 == 2'h1 && o_flow_change) else $error("invoke not two cycles");
    AST_BIT_GROUP: assert property (take && i_instr[13:12] == GRP_BIT |=> o_group == GROUP_BIT)
        else $error("bit group not flagged");
    AST_READ_FIRST: assert property (o_file_read |-> o_phase == PHASE_Q2 && o_cycle_index == 2'h0)
        else $error("file read outside first cycle");
    AST_WRITE_LAST: assert property (o_file_write || o_acc_write |-> o_phase == PHASE_Q4 &&
        o_cycle_index == o_total_cycles_m1 && !(o_file_write && o_acc_write))
        else $error("write strobe misplaced");
    AST_ACC_LOAD: assert property (o_acc_write |=> o_acc == $past(i_result))
        else $error("accumulator not loaded");
    cover property (take && i_instr[13:11] == OP_INVOKE);
    cover property (o_file_write);
    cover property (o_acc_write);
    cover property (o_busy && o_total_cycles_m1 == 2'h2);
endmodule : instr_cycle_decode_assertions

bind instr_cycle_decode instr_cycle_decode_assertions chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_instr(i_instr), .i_instr_valid(i_instr_valid), .i_result(i_result),
    .o_instr_ready(o_instr_ready), .o_busy(o_busy), .o_phase(o_phase),
    .o_cycle_index(o_cycle_index), .o_total_cycles_m1(o_total_cycles_m1), .o_group(o_group),
    .o_file_addr(o_file_addr), .o_dest_file(o_dest_file), .o_bit_index(o_bit_index),
    .o_lit11(o_lit11), .o_step_mode(o_step_mode), .o_flow_change(o_flow_change),
    .o_file_read(o_file_read), .o_file_write(o_file_write), .o_acc_write(o_acc_write),
    .o_acc(o_acc));

// *** sim/instr_cycle_decode_tb.sv ***
// Purpose: Self-checking bench for the instruction cycle decoder
// Assumes: Bench inputs change on falling edges; memory model feeds the words on rising edges
// Notes: Strobes are counted per instruction from its take onwards
module instr_cycle_decode_tb;
    import instr_cycle_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [1:0] ptr_mem = 2'h0;
    logic [7:0] result = 8'h00;
    logic [13:0] instr;
    logic valid, ready, rd, fw, aw, psel;
    logic [1:0] m1;
    logic [7:0] acc;
    group_t grp;
    step_mode_sel_t mode;
    int miscompares = 0;
    int total_checks = 0;
    int n_rd, n_fw, n_aw;
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        n_rd += int'(rd);
        n_fw += int'(fw);
        n_aw += int'(aw);
    end
    prog_mem_model mem (.i_clk(i_clk), .i_ready(ready), .o_instr(instr), .o_valid(valid));
    instr_cycle_decode dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_instr(instr),
        .i_instr_valid(valid), .i_ptr_in_progmem(ptr_mem), .i_result(result),
        .o_instr_ready(ready), .o_busy(), .o_phase(), .o_cycle_index(),
        .o_total_cycles_m1(m1), .o_group(grp), .o_file_addr(), .o_dest_file(),
        .o_bit_index(), .o_lit8(), .o_lit11(), .o_lit9(), .o_lit7(), .o_lit6(), .o_lit5(),
        .o_ptr_sel(psel), .o_step_mode(mode), .o_flow_change(), .o_file_read(rd),
        .o_file_write(fw), .o_acc_write(aw), .o_acc(acc));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic issue(input logic [13:0] w, input logic [1:0] ptr);
        int n;
        @(negedge i_clk);
        ptr_mem = ptr;
        mem.words.push_back(w);
        for (n = 0; n < 64 && mem.took !== 1'b1; n++)
            @(negedge i_clk);
        n_rd = 0;
        n_fw = 0;
        n_aw = 0;
    endtask : issue
    task automatic run(input logic [13:0] w, input logic [1:0] ptr, input logic [1:0] em1,
        input group_t eg, input int erd, input int efw, input int eaw);
        issue(w, ptr);
        check(m1, em1);
        check(grp, eg);
        repeat (4 * (em1 + 1)) @(negedge i_clk);
        if (erd >= 0)
            check(n_rd, erd);
        check(n_fw, efw);
        check(n_aw, eaw);
    endtask : run
    task automatic t_lengths();
        run(14'h07a5, 2'h0, 2'h0, GROUP_BYTE, 1, 1, 0);
        run(14'h00a5, 2'h0, 2'h0, GROUP_BYTE, 1, 1, 0);
        run(14'h1525, 2'h0, 2'h0, GROUP_BIT, 1, 1, 0);
        run(14'h3012, 2'h0, 2'h0, GROUP_LITCTRL, 0, 0, 1);
        run(14'h2123, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 0);
        run(14'h000a, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 0);
        run(14'h0008, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 0);
        run(14'h0009, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 0);
        run(14'h3455, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 1);
        run(14'h2fff, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 0);
        run(14'h3300, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 0);
        run(14'h000b, 2'h0, 2'h1, GROUP_LITCTRL, 0, 0, 0);
        run(14'h1825, 2'h0, 2'h1, GROUP_BIT, 1, 0, 0);
        run(14'h1c25, 2'h0, 2'h1, GROUP_BIT, 1, 0, 0);
        run(14'h0f25, 2'h0, 2'h1, GROUP_BYTE, 1, 0, 1);
        run(14'h0b80, 2'h1, 2'h2, GROUP_BYTE, 1, 1, 0);
        run(14'h0781, 2'h1, 2'h0, GROUP_BYTE, 1, 1, 0);
        run(14'h0781, 2'h2, 2'h1, GROUP_BYTE, 1, 1, 0);
    endtask : t_lengths
    task automatic t_steps();
        for (int s = 0; s < 8; s++)
        begin
            issue(14'h0010 | 14'(s), 2'h1);
            check(mode, s % 4);
            check(psel, s / 4);
            check(m1, s < 4);
        end
    endtask : t_steps
    task automatic t_acc();
        result = 8'h5a;
        run(14'h0103, 2'h0, 2'h0, GROUP_BYTE, -1, 0, 1);
        check(acc, 8'h5a);
        result = 8'h3c;
        run(14'h0100, 2'h0, 2'h0, GROUP_BYTE, -1, 0, 1);
        check(acc, 8'h3c);
        result = 8'hc3;
        run(14'h07a5, 2'h0, 2'h0, GROUP_BYTE, 1, 1, 0);
        check(acc, 8'h3c);
    endtask : t_acc
    task automatic t_b2b();
        int n;
        @(negedge i_clk);
        mem.words.push_back(14'h0000);
        mem.words.push_back(14'h2155);
        mem.words.push_back(14'h0000);
        for (n = 0; n < 64 && mem.took !== 1'b1; n++)
            @(negedge i_clk);
        repeat (4) @(negedge i_clk);
        check(mem.took, 1'b1);
        repeat (8) @(negedge i_clk);
        check(mem.took, 1'b1);
    endtask : t_b2b
    initial
    begin
        repeat (10) @(negedge i_clk);
        i_rst_b = 1'b1;
        t_lengths();
        t_steps();
        t_acc();
        t_b2b();
        conclude();
    end
    // About 32 instructions of at most 12 clocks each fit well inside this span
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule : instr_cycle_decode_tb

// *** sim/prog_mem_model.sv ***
// Purpose: Program memory stand-in that streams queued words to the decoder
// Assumes: Words are queued by the bench on falling edges
// Notes: Idle data toggles so a stale word can never be mistaken for a fresh one
module prog_mem_model
    import instr_cycle_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ready,
    output logic [instr_cycle_pkg::INSTR_W-1:0] o_instr,
    output logic o_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [INSTR_W-1:0] words[$];
    logic took = 1'b0;
    initial o_instr = '0;
    initial o_valid = 1'b0;
    always @(posedge i_clk)
    begin
        took <= i_ready && o_valid;
        if (i_ready && o_valid)
            void'(words.pop_front());
        o_valid <= words.size() > 0;
        o_instr <= (words.size() > 0) ? words[0] : ~o_instr;
    end
endmodule : prog_mem_model
